// ===== hw/lssc_pkg.sv
package lssc_pkg;
   // Register offsets
   localparam logic [7:0] LSSC_OFF_LSC = 8'h78;
   localparam logic [7:0] LSSC_OFF_SCAP = 8'h7c;
   // Link control bit positions
   localparam int LSSC_BIT_RETRAIN = 5;
   localparam int LSSC_BIT_BWM_IE = 10;
   localparam int LSSC_BIT_ABW_IE = 11;
   // Link status bit positions
   localparam int LSSC_BIT_TRAIN = 27;
   localparam int LSSC_BIT_SCLK = 28;
   localparam int LSSC_BIT_DLACT = 29;
   localparam int LSSC_BIT_BWM = 30;
   localparam int LSSC_BIT_ABW = 31;
   // Slot capability bit positions
   localparam int LSSC_BIT_ABP = 0;
   localparam int LSSC_BIT_PCP = 1;
   localparam int LSSC_BIT_MRLP = 2;
   localparam int LSSC_BIT_AIP = 3;
   localparam int LSSC_BIT_PIP = 4;
   localparam int LSSC_BIT_HPS = 5;
   localparam int LSSC_BIT_HPC = 6;
   localparam int LSSC_POS_PLV = 7;
   localparam int LSSC_POS_PLS = 15;
   localparam int LSSC_BIT_EMIP = 17;
   // Reset values
   localparam logic [7:0] LSSC_RST_PLV = 8'h19;
   localparam logic [1:0] LSSC_RST_PLS = 2'h0;
   localparam logic [31:0] LSSC_ZERO = 32'h0000_0000;
   // Edges after reset before synced expander pin is trusted
   localparam logic [1:0] LSSC_STRAP_WAIT = 2'h2;

   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        ldr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } lssc_req_t;

   // Link-layer events from the port core
   typedef struct packed {
      logic training;
      logic dl_active;
      logic dl_down;
      logic retrain_done;
      logic rel_change;
      logic auto_change;
   } lssc_link_t;

   // Power-limit message handshake states
   typedef enum logic [1:0] {LSSC_IDLE, LSSC_REQ, LSSC_WAIT} lssc_msg_st_t;
endpackage

// ===== hw/lssc_regs.sv
`timescale 1ns/100ps
// Functional notes
// RQ1 - Bit 27 shows retraining pending or active
// RQ2 - Bit 28 reports slot clock configuration; code reports the value set by loader writes and leaves slot_clk_cfg unused
// RQ3 - Bit 29 shows data link active
// RQ4 - Retrain completion sets bit 30, W1C
// RQ5 - Reliability speed/width change sets bit 30
// RQ6 - Autonomous bandwidth change sets bit 31, W1C
// RQ7 - Receiver L0s entry never gated by control
// RQ8 - Hot-plug bits default from hot-plug capability
// RQ9 - Serial hot-plug needs detected I/O expander
// RQ10 - No power controller keeps slot disabled
// RQ11 - Power slot when latch closed, control clear
// RQ12 - Latch sensed, low means closed
// RQ13 - Button/indicator present bits follow expander
// RQ14 - Hot-plug surprise bit defaults to zero
// RQ15 - Hot-plug capable bit follows expander
// RQ16 - Power limit value defaults to 19h
// RQ17 - Power limit field always implemented
// RQ18 - Capability write or link up sends message; code counts link up only while dlar_cap is set
// RQ19 - Interlock bit reserved without serial hot-plug
// RQ20 - Scale codes 1.0, 0.1, 0.01, 0.001
// RQ21 - Retrain write starts retraining, reads zero
// RQ22 - Bit 30 set raises interrupt when enabled
// RQ23 - Bit 31 set raises interrupt when enabled
// RQ24 - Active reporting capability defaults to one
module lssc_regs
   import lssc_pkg::*;
#(
   parameter bit DOWNSTREAM = 1'b1,
   parameter bit HP_CAPABLE = 1'b1
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ce,
   input  wire lssc_req_t  req,
   input  wire lssc_link_t link,
   input  wire logic       dlar_cap,
   input  wire logic       slot_clk_cfg,
   input  wire logic       expander_present,
   input  wire logic       latch_n,
   input  wire logic       pwr_ctrl_off,
   input  wire logic       msg_ack,
   output logic            rd_valid,
   output logic [31:0]     rd_data,
   output logic            retrain_req,
   output logic            msg_req,
   output logic [9:0]      msg_payload,
   output logic            irq,
   output logic            slot_power_on,
   output logic            hp_ctrl_enable,
   output logic            l0s_rx_allowed
);
   initial begin
      if (!DOWNSTREAM && HP_CAPABLE) begin
         $error("Hot-plug needs a downstream port");
      end
   end

   typedef struct packed {
      logic        rd_valid;
      logic [31:0] rd_data;
      logic        bwm_ie;
      logic        abw_ie;
      logic        bwm_st;
      logic        abw_st;
      logic        sclk;
      logic [6:0]  cap_lo;
      logic [7:0]  plv;
      logic [1:0]  pls;
      logic        emip;
      logic        retrain_pend;
      logic        retrain_sw;
      logic        dla_q;
      logic        msg_pend;
      lssc_msg_st_t msg_st;
      logic        msg_req;
      logic [9:0]  msg_pl;
      logic        irq;
      logic        pwr_on;
      logic        hp_en;
      logic        strap_done;
      logic [1:0]  strap_cnt;
   } lssc_st_t;

   lssc_st_t st_reg;
   lssc_st_t st_next;
   logic [1:0] pin_s;

   // Pins from the I/O expander cross in through two flops
   lssc_sync #(
      .W (2)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .d       ({expander_present, latch_n}),
      .q       (pin_s)
   );

   // Serial hot-plug capability only with an expander seen
   function automatic logic serial_hp(input logic exp);
      return DOWNSTREAM && HP_CAPABLE && exp; // RQ9
   endfunction

   function automatic logic [31:0] lsc_read(input lssc_st_t s, input logic act,
                                            input logic trn);
      logic [31:0] v;
      v = LSSC_ZERO;
      if (DOWNSTREAM) begin
         v[LSSC_BIT_BWM_IE] = s.bwm_ie;
         v[LSSC_BIT_ABW_IE] = s.abw_ie;
         v[LSSC_BIT_TRAIN] = trn; // RQ1
         v[LSSC_BIT_DLACT] = act; // RQ3
         v[LSSC_BIT_BWM] = s.bwm_st;
         v[LSSC_BIT_ABW] = s.abw_st;
      end
      v[LSSC_BIT_SCLK] = s.sclk; // RQ2
      return v; // Retrain bit always reads zero RQ21
   endfunction

   function automatic logic [31:0] scap_read(input lssc_st_t s);
      logic [31:0] v;
      v = LSSC_ZERO;
      if (DOWNSTREAM) begin
         v[6:0] = s.cap_lo;
         v[LSSC_POS_PLV +: 8] = s.plv; // RQ17
         v[LSSC_POS_PLS +: 2] = s.pls; // RQ20
         v[LSSC_BIT_EMIP] = s.emip;
      end
      return v;
   endfunction

   // Next state: loader writes, status flags, message and slot power
   always_comb begin
      logic        act;
      logic        trn;
      logic        w_lsc;
      logic        w_scap;
      logic        shp;
      logic        dl_up;
      logic        cap_trig;
      act = DOWNSTREAM && dlar_cap && link.dl_active; // RQ3 RQ24
      st_next = st_reg;
      trn = st_reg.retrain_pend || link.training;
      w_lsc = req.wr && req.addr == LSSC_OFF_LSC;
      w_scap = req.wr && req.ldr && req.addr == LSSC_OFF_SCAP && DOWNSTREAM;
      shp = serial_hp(pin_s[1]);
      dl_up = act && !st_reg.dla_q;
      cap_trig = 1'b0;
      if (ce) begin
         st_next.dla_q = act;
         st_next.rd_valid = req.rd;
         if (req.rd) begin
            st_next.rd_data = (req.addr == LSSC_OFF_LSC) ? lsc_read(st_reg, act, trn) :
                              (req.addr == LSSC_OFF_SCAP) ? scap_read(st_reg) : LSSC_ZERO;
         end
         // Capability defaults follow the synced pin until the synchroniser has filled
         if (!st_reg.strap_done) begin
            st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
            st_next.strap_done = (st_reg.strap_cnt == LSSC_STRAP_WAIT);
            st_next.cap_lo = {shp, 1'b0, {5{shp}}}; // RQ8 RQ13 RQ14 RQ15
            st_next.emip = shp; // RQ8 RQ19
         end
         if (w_lsc && DOWNSTREAM) begin
            st_next.bwm_ie = req.wdata[LSSC_BIT_BWM_IE];
            st_next.abw_ie = req.wdata[LSSC_BIT_ABW_IE];
            if (req.wdata[LSSC_BIT_RETRAIN]) begin
               st_next.retrain_pend = 1'b1; // RQ21
               st_next.retrain_sw = 1'b1;
            end
            if (req.wdata[LSSC_BIT_BWM]) st_next.bwm_st = 1'b0; // RQ4
            if (req.wdata[LSSC_BIT_ABW]) st_next.abw_st = 1'b0; // RQ6
         end
         if (w_lsc && req.ldr) begin
            st_next.sclk = req.wdata[LSSC_BIT_SCLK]; // RQ2
         end
         if (w_scap) begin
            st_next.cap_lo = req.wdata[6:0];
            st_next.plv = req.wdata[LSSC_POS_PLV +: 8];
            st_next.pls = req.wdata[LSSC_POS_PLS +: 2];
            st_next.emip = shp && req.wdata[LSSC_BIT_EMIP]; // RQ19
            cap_trig = 1'b1;
         end
         if (link.training) st_next.retrain_pend = 1'b0;
         if (link.dl_down) st_next.retrain_sw = 1'b0;
         // Set wins over a same-cycle clear
         if (DOWNSTREAM && !link.dl_down) begin
            if (link.retrain_done && st_reg.retrain_sw) begin
               st_next.bwm_st = 1'b1; // RQ4
               st_next.retrain_sw = 1'b0;
            end
            if (link.rel_change) st_next.bwm_st = 1'b1; // RQ5
            if (link.auto_change) st_next.abw_st = 1'b1; // RQ6
         end
         st_next.irq = (st_next.bwm_st && !st_reg.bwm_st && st_next.bwm_ie) || // RQ22
                       (st_next.abw_st && !st_reg.abw_st && st_next.abw_ie);   // RQ23
         // Power limit message queued on capability write or on link up while dlar_cap is set
         if (DOWNSTREAM && (cap_trig || dl_up)) st_next.msg_pend = 1'b1; // RQ18
         case (st_reg.msg_st)
            LSSC_IDLE: begin
               if (st_reg.msg_pend) begin
                  st_next.msg_pend = cap_trig || dl_up;
                  st_next.msg_req = 1'b1;
                  st_next.msg_pl = {st_reg.pls, st_reg.plv}; // RQ18
                  st_next.msg_st = LSSC_REQ;
               end
            end
            LSSC_REQ: begin
               if (msg_ack) begin
                  st_next.msg_req = 1'b0;
                  st_next.msg_st = LSSC_IDLE;
               end
            end
            default: begin
               st_next.msg_req = 1'b0;
               st_next.msg_st = LSSC_IDLE;
            end
         endcase
         // Slot power: latch position ignored without sensor
         st_next.hp_en = shp && st_reg.cap_lo[LSSC_BIT_PCP]; // RQ10
         st_next.pwr_on = st_next.hp_en && !pwr_ctrl_off &&
                          (!st_reg.cap_lo[LSSC_BIT_MRLP] || !pin_s[0]); // RQ11 RQ12
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.plv <= LSSC_RST_PLV; // RQ16
         st_reg.pls <= LSSC_RST_PLS;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from state flops
   assign rd_valid = st_reg.rd_valid;
   assign rd_data = st_reg.rd_data;
   assign retrain_req = st_reg.retrain_pend;
   assign msg_req = st_reg.msg_req;
   assign msg_payload = st_reg.msg_pl;
   assign irq = st_reg.irq;
   assign slot_power_on = st_reg.pwr_on;
   assign hp_ctrl_enable = st_reg.hp_en;
   assign l0s_rx_allowed = st_reg.strap_done; // RQ7 not gated by ASPM control
endmodule

// ===== hw/lssc_sync.sv
`timescale 1ns/100ps
module lssc_sync
   import lssc_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lssc_sync_t;
   lssc_sync_t st_reg;
   lssc_sync_t st_next;

   // Two-stage synchroniser; first stage feeds only the second
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.s1 = d;
         st_next.s2 = st_reg.s1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule

// ===== verification/lssc_link_partner.sv
`timescale 1ns/100ps
module lssc_link_partner (
   input  wire logic clk,
   input  wire logic retrain_req,
   input  wire logic msg_req,
   input  wire logic slow,
   output logic      training,
   output logic      retrain_done,
   output logic      msg_ack
);
   logic [2:0] t_cnt = 3'h0;
   logic [2:0] a_cnt = 3'h0;
   initial begin
      training = 1'b0;
      retrain_done = 1'b0;
      msg_ack = 1'b0;
   end
   // Retraining lasts a few cycles, then a one-cycle completion pulse
   always @(negedge clk) begin
      if (retrain_req && t_cnt == 3'h0)
         t_cnt <= 3'h5;
      else if (t_cnt != 3'h0)
         t_cnt <= t_cnt - 3'h1;
      training     <= (t_cnt > 3'h1) || (retrain_req && t_cnt == 3'h0);
      retrain_done <= t_cnt == 3'h1;
   end
   // Message taken at once or after a stall, so both paths get exercised
   always @(negedge clk) begin
      a_cnt   <= (msg_req && !msg_ack) ? a_cnt + 3'h1 : 3'h0;
      msg_ack <= msg_req && !msg_ack && a_cnt >= (slow ? 3'h3 : 3'h0);
   end
endmodule

// ===== verification/lssc_regs_monitor.sv
`timescale 1ns/100ps
module lssc_regs_monitor
   import lssc_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ce,
   input wire lssc_req_t   req,
   input wire lssc_link_t  link,
   input wire logic        dlar_cap,
   input wire logic        msg_ack,
   input wire logic        pwr_ctrl_off,
   input wire logic [31:0] rd_data,
   input wire logic        retrain_req,
   input wire logic        msg_req,
   input wire logic        slot_power_on,
   input wire logic        l0s_rx_allowed
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Read of the link status word taken this cycle
   sequence s_lsc_rd;
      ce && req.rd && req.addr == LSSC_OFF_LSC;
   endsequence
   a_retrain_start: assert property (
      ce && req.wr && req.addr == LSSC_OFF_LSC && req.wdata[5] && !link.training
      |=> retrain_req) else $error("retrain not requested");
   a_retrain_rdzero: assert property (
      s_lsc_rd |=> !rd_data[5]) else $error("retrain bit reads one");
   a_train_flag: assert property (
      link.training ##1 (link.training and s_lsc_rd) |=> rd_data[27])
      else $error("training flag low");
   a_idle_flag: assert property (
      (!retrain_req && !link.training) [*2] ##0 s_lsc_rd |=> !rd_data[27])
      else $error("training flag high");
   a_dlact_bit: assert property (
      link.dl_active && dlar_cap ##1 ((link.dl_active && dlar_cap) and s_lsc_rd)
      |=> rd_data[29]) else $error("link active bit low");
   a_l0s_keep: assert property (
      l0s_rx_allowed |=> l0s_rx_allowed) else $error("l0s entry withdrawn");
   a_msg_hold: assert property (
      msg_req && !msg_ack |=> msg_req) else $error("message dropped");
   a_power_off: assert property (
      pwr_ctrl_off [*3] |-> !slot_power_on) else $error("slot powered while off");
endmodule
bind lssc_regs lssc_regs_monitor u_mon (.clk(clk), .reset_n(reset_n), .ce(ce), .req(req),
   .link(link), .dlar_cap(dlar_cap), .msg_ack(msg_ack), .pwr_ctrl_off(pwr_ctrl_off),
   .rd_data(rd_data), .retrain_req(retrain_req), .msg_req(msg_req),
   .slot_power_on(slot_power_on), .l0s_rx_allowed(l0s_rx_allowed));

// ===== verification/test_lssc_regs.sv
`timescale 1ns/100ps
module test_lssc_regs
   import lssc_pkg::*;
;
   logic        clk, reset_n, latch_n, pwr_ctrl_off, dl_act, rel_ch, auto_ch, slow;
   logic        p_trn, p_done, msg_ack, rd_valid, retrain_req, msg_req, irq, irq_seen;
   logic        slot_power_on, l0s_rx_allowed;
   logic [1:0]  sc;
   logic [9:0]  msg_payload;
   logic [31:0] rd_data, rdat;
   lssc_req_t   req;
   lssc_link_t  link;
   int          errors, n_checks, i;
   assign link = {p_trn, dl_act, 1'b0, p_done, rel_ch, auto_ch};
   lssc_regs DUT (.clk(clk), .reset_n(reset_n), .ce(1'b1), .req(req), .link(link),
      .dlar_cap(1'b1), .slot_clk_cfg(1'b0), .expander_present(1'b1), .latch_n(latch_n),
      .pwr_ctrl_off(pwr_ctrl_off), .msg_ack(msg_ack), .rd_valid(rd_valid), .rd_data(rd_data),
      .retrain_req(retrain_req), .msg_req(msg_req), .msg_payload(msg_payload), .irq(irq),
      .slot_power_on(slot_power_on), .hp_ctrl_enable(), .l0s_rx_allowed(l0s_rx_allowed));
   lssc_link_partner u_far (.clk(clk), .retrain_req(retrain_req), .msg_req(msg_req),
      .slow(slow), .training(p_trn), .retrain_done(p_done), .msg_ack(msg_ack));
   // Latch the one-cycle interrupt pulse for later judgement
   always @(posedge clk)
      if (irq === 1'b1) irq_seen <= 1'b1;
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic ld);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, ldr: ld, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask
   task rd(input logic [7:0] a);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, ldr: 1'b0, addr: a, wdata: 32'h0000_0000};
      @(negedge clk);
      req = '0;
      chk({31'h0, rd_valid}, 32'h0000_0001);
      rdat = rd_data;
   endtask
   function logic pick(input int s);
      return s == 0 ? p_trn : (s == 1 ? msg_req : slot_power_on);
   endfunction
   // Bounded wait; a hang ends the run at once
   task wait_sig(input int s, input logic lvl);
      for (i = 0; i < 40 && pick(s) !== lvl; i++)
         @(negedge clk);
      chk({31'h0, pick(s)}, {31'h0, lvl});
      if (pick(s) !== lvl) tally_and_finish;
   endtask
   task t_defaults;
      repeat (4) @(negedge clk);
      rd(LSSC_OFF_SCAP);
      chk(rdat, 32'h0002_0CDF);
      rd(LSSC_OFF_LSC);
      chk(rdat, LSSC_ZERO);
      rd(8'h40);
      chk(rdat, LSSC_ZERO);
      chk({31'h0, l0s_rx_allowed}, 32'h0000_0001);
   endtask
   task t_retrain;
      irq_seen = 1'b0;
      wr(LSSC_OFF_LSC, 32'h0000_0420, 1'b0);
      wait_sig(0, 1'b1);
      rd(LSSC_OFF_LSC);
      chk(rdat & 32'h0800_0020, 32'h0800_0000);
      wait_sig(0, 1'b0);
      rd(LSSC_OFF_LSC);
      chk(rdat & 32'hC800_0000, 32'h4000_0000);
      chk({31'h0, irq_seen}, 32'h0000_0001);
      wr(LSSC_OFF_LSC, 32'h4000_0400, 1'b0);
   endtask
   // Reliability then autonomous change, each cleared by writing one
   task t_hw_change;
      for (int j = 0; j < 2; j++) begin
         irq_seen = 1'b0;
         rel_ch = j == 0;
         auto_ch = j == 1;
         @(negedge clk);
         rel_ch = 1'b0;
         auto_ch = 1'b0;
         rd(LSSC_OFF_LSC);
         chk(rdat & 32'hC000_0000, j ? 32'h8000_0000 : 32'h4000_0000);
         chk({31'h0, irq_seen}, 32'h0000_0001);
         wr(LSSC_OFF_LSC, 32'hC000_0C00, 1'b0);
         rd(LSSC_OFF_LSC);
         chk(rdat & 32'hC000_0000, LSSC_ZERO);
      end
   endtask
   task t_link_up;
      slow = 1'b1;
      dl_act = 1'b1;
      wait_sig(1, 1'b1);
      chk({22'h0, msg_payload}, 32'h0000_0019);
      wait_sig(1, 1'b0);
      rd(LSSC_OFF_LSC);
      chk(rdat & 32'h2000_0000, 32'h2000_0000);
      slow = 1'b0;
   endtask
   // Every scale code, then a plain write that must not land
   task t_cap_write;
      for (int k = 0; k < 4; k++) begin
         sc = k[1:0];
         wr(LSSC_OFF_SCAP, {14'h0, 1'b1, sc, 6'h08, sc, 7'h5F}, 1'b1);
         wait_sig(1, 1'b1);
         chk({22'h0, msg_payload}, {22'h0, sc, 6'h08, sc});
         wait_sig(1, 1'b0);
      end
      wr(LSSC_OFF_SCAP, LSSC_ZERO, 1'b0);
      rd(LSSC_OFF_SCAP);
      chk(rdat, 32'h0003_91DF);
   endtask
   task t_power;
      latch_n = 1'b0;
      pwr_ctrl_off = 1'b0;
      wait_sig(2, 1'b1);
      latch_n = 1'b1;
      wait_sig(2, 1'b0);
      latch_n = 1'b0;
      wait_sig(2, 1'b1);
      pwr_ctrl_off = 1'b1;
      wait_sig(2, 1'b0);
   endtask
   // Watchdog against a hang anywhere in the sequence
   initial begin
      repeat (20000) @(posedge clk);
      chk(LSSC_ZERO, 32'h0000_0001);
      tally_and_finish;
   end
   initial begin
      {reset_n, dl_act, rel_ch, auto_ch, slow, irq_seen, latch_n, pwr_ctrl_off} = 8'h03;
      req = '0;
      errors = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      t_defaults;
      t_retrain;
      t_hw_change;
      t_link_up;
      t_cap_write;
      t_power;
      tally_and_finish;
   end
endmodule
